// ===== sstc_defs.svh
/*
  Register offsets, field positions, reset values and clamp floors of the
  scan sequence and conversion timing control block.
  Assumes inclusion by bare name from package and modules alike.
*/
`ifndef SSTC_DEFS_SVH
`define SSTC_DEFS_SVH

// ****************************************
// Register offsets
// ****************************************
`define SSTC_ADDR_FILL    8'h01
`define SSTC_ADDR_STATUS  8'h04
`define SSTC_ADDR_OSC     8'h18
`define SSTC_ADDR_CYCLE   8'h19
`define SSTC_ADDR_MODE    8'h1C
`define SSTC_ADDR_LAUNCH  8'h1E
`define SSTC_ADDR_CANCEL  8'h1F
`define SSTC_ADDR_CHEN    8'h20

// ****************************************
// Field positions and codes
// ****************************************
`define SSTC_BIT_CTRL     0
`define SSTC_BIT_AUTO     2
`define SSTC_BIT_LOOP     1
`define SSTC_FAULT_OFF    2'h0
`define SSTC_FAULT_OK     2'h1
`define SSTC_FAULT_ERR    2'h3

// ****************************************
// Reset values and limits
// ****************************************
`define SSTC_RST_OSC      1'h0
`define SSTC_RST_CYCLE    8'h00
`define SSTC_RST_MODE     3'h0
`define SSTC_RST_CHEN     2'h3
`define SSTC_FILL_MAX     5'h10
`define SSTC_FLOOR_HS     8'h15
`define SSTC_FLOOR_LP     8'h12

`endif

// ===== sstc_pkg.sv
/*
  Types and shared functions of the scan sequence and timing control block.
  Assumes sstc_defs.svh is on the include path.
*/
`include "sstc_defs.svh"

package sstc_pkg;

  // ****************************************
  // Sequencer states
  // ****************************************
  typedef enum logic [1:0]
  {
    SSTC_IDLE = 2'h0,
    SSTC_CONV = 2'h1,
    SSTC_ADV  = 2'h3
  } sstc_seq_t;

  typedef struct packed
  {
    sstc_seq_t  seq;
    logic       busy;
    logic       chan;
    logic [1:0] fault;
    logic [4:0] fill;
    logic       osc;
    logic [7:0] cycClk;
    logic [2:0] mode;
    logic [1:0] chEn;
    logic [7:0] rdData;
    logic       rdValid;
    logic       convDone;
  } sstc_state_t;

  typedef struct packed
  {
    logic [1:0] sync1;
    logic [1:0] sync2;
    logic [1:0] prev;
    logic [7:0] cnt;
    logic       done;
  } sstc_tmr_t;

  // ****************************************
  // Functions
  // ****************************************
  function automatic logic sstc_auto(input logic [2:0] mode);
    return mode[`SSTC_BIT_AUTO];
  endfunction

  function automatic logic [7:0] sstc_clamp(input logic lp, input logic [7:0] x);
    logic [7:0] floorVal;
    floorVal = lp ? `SSTC_FLOOR_LP : `SSTC_FLOOR_HS;
    return (x <= floorVal) ? floorVal : x;
  endfunction

endpackage

// ===== sstc_cycle_timer.sv
/*
  Conversion cycle timer: counts periods of the selected oscillator.
  Assumes both oscillator inputs are asynchronous and slower than half of clk_sys.
*/
`timescale 1ns/1ps
`include "sstc_defs.svh"

module sstc_cycle_timer
(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  // Oscillator pins
  input  wire logic       hsOscClk,
  input  wire logic       lpOscClk,
  // Control
  input  wire logic       lowPower,
  input  wire logic [7:0] cycleClocks,
  input  wire logic       enable,
  // Result
  output logic            done
);
  import sstc_pkg::*;

  sstc_tmr_t  st;
  sstc_tmr_t  next_st;
  logic [7:0] effClocks;
  logic       tick;

  // ****************************************
  // Counting
  // ****************************************
  always_comb
  begin
    next_st       = st;
    next_st.sync1 = {lpOscClk, hsOscClk};
    next_st.sync2 = st.sync1;
    next_st.prev  = st.sync2;
    next_st.done  = 1'b0;
    effClocks     = sstc_clamp(lowPower, cycleClocks);
    tick          = st.sync2[lowPower] & ~st.prev[lowPower];
    if (!enable)
    begin
      next_st.cnt = 8'h00;
    end
    else if (tick)
    begin
      if (st.cnt + 8'h01 >= effClocks)
      begin
        next_st.cnt  = 8'h00;
        next_st.done = 1'b1;
      end
      else
      begin
        next_st.cnt = st.cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign done = st.done;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_clamp_floor: assert property (effClocks >= (lowPower ? `SSTC_FLOOR_LP : `SSTC_FLOOR_HS))
    else $error("Effective cycle clock count below floor");
  a_cycle_end: assert property (done |-> $past(st.cnt) + 8'h01 >= $past(effClocks))
    else $error("Conversion cycle ended before count reached");
endmodule

// ===== sstc_scan_ctrl.sv
/*
  Scan sequence and conversion timing control: register file and sequencer.
  Assumes the two-wire front end delivers byte register accesses and
  general-call reset as single-cycle strobes on clk_sys.
*/
`timescale 1ns/1ps
`include "sstc_defs.svh"

module sstc_scan_ctrl
(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  // Register access from two-wire front end
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  input  wire logic       gcReset,
  output logic      [7:0] regRdData,
  output logic            regRdValid,
  // Oscillator pins
  input  wire logic       hsOscClk,
  input  wire logic       lpOscClk,
  // Converter side
  output logic            busyPin,
  output logic            activeChannel,
  output logic            convDone,
  output logic            oscLowPower
);
  import sstc_pkg::*;

  localparam sstc_state_t RST_STATE = '{
    seq:      SSTC_IDLE,
    busy:     1'b0,
    chan:     1'b0,
    fault:    `SSTC_FAULT_OFF,
    fill:     5'h00,
    osc:      `SSTC_RST_OSC,
    cycClk:   `SSTC_RST_CYCLE,
    mode:     `SSTC_RST_MODE,
    chEn:     `SSTC_RST_CHEN,
    rdData:   8'h00,
    rdValid:  1'b0,
    convDone: 1'b0
  };

  sstc_state_t st;
  sstc_state_t next_st;
  logic        tmrDone;
  logic        launchWr;
  logic        cancelWr;
  logic        autoOn;

  // ****************************************
  // Cycle timer
  // ****************************************
  sstc_cycle_timer u_timer
  (
    .clk_sys     (clk_sys),
    .rst_n       (rst_n),
    .hsOscClk    (hsOscClk),
    .lpOscClk    (lpOscClk),
    .lowPower    (st.osc),
    .cycleClocks (st.cycClk),
    .enable      (st.seq == SSTC_CONV),
    .done        (tmrDone)
  );

  // ****************************************
  // Registers and sequencer
  // ****************************************
  always_comb
  begin
    next_st          = st;
    next_st.rdValid  = regRead;
    next_st.convDone = 1'b0;
    autoOn           = sstc_auto(st.mode);
    launchWr = regWrite && regAddr == `SSTC_ADDR_LAUNCH && regWrData[`SSTC_BIT_CTRL];
    cancelWr = regWrite && regAddr == `SSTC_ADDR_CANCEL && regWrData[`SSTC_BIT_CTRL];

    unique case (regAddr)
      `SSTC_ADDR_FILL:   next_st.rdData = {3'h0, st.fill};
      `SSTC_ADDR_STATUS: next_st.rdData = {5'h00, st.fault, 1'b0};
      `SSTC_ADDR_OSC:    next_st.rdData = {7'h00, st.osc};
      `SSTC_ADDR_CYCLE:  next_st.rdData = sstc_clamp(st.osc, st.cycClk);
      `SSTC_ADDR_MODE:   next_st.rdData = {5'h00, st.mode};
      `SSTC_ADDR_CHEN:   next_st.rdData = {6'h00, st.chEn};
      default:           next_st.rdData = 8'h00;
    endcase

    if (regWrite)
    begin
      unique case (regAddr)
        `SSTC_ADDR_OSC:   next_st.osc    = regWrData[`SSTC_BIT_CTRL];
        `SSTC_ADDR_CYCLE: next_st.cycClk = regWrData;
        `SSTC_ADDR_MODE:  next_st.mode   = regWrData[2:0];
        `SSTC_ADDR_CHEN:  next_st.chEn   = regWrData[1:0];
        default:          next_st.cycClk = st.cycClk;
      endcase
    end

    if (cancelWr)
    begin
      next_st.seq  = SSTC_IDLE;
      next_st.busy = 1'b0;
    end
    else if (launchWr)
    begin
      next_st.fill = 5'h00;
      if (autoOn && st.chEn == 2'h0)
      begin
        next_st.fault = `SSTC_FAULT_ERR;
        next_st.seq   = SSTC_IDLE;
        next_st.busy  = 1'b0;
      end
      else
      begin
        next_st.fault = autoOn ? `SSTC_FAULT_OK : `SSTC_FAULT_OFF;
        next_st.seq   = SSTC_CONV;
        next_st.busy  = 1'b1;
        next_st.chan  = autoOn ? ~st.chEn[0] : 1'b0;
      end
    end
    else
    begin
      unique case (st.seq)
        SSTC_IDLE: next_st.seq = SSTC_IDLE;
        SSTC_CONV:
        begin
          if (tmrDone)
          begin
            next_st.convDone = 1'b1;
            next_st.seq      = SSTC_ADV;
            if (st.fill != `SSTC_FILL_MAX)
            begin
              next_st.fill = st.fill + 5'h01;
            end
          end
        end
        SSTC_ADV:
        begin
          if (autoOn && !st.chan && st.chEn[1])
          begin
            next_st.chan = 1'b1;
            next_st.seq  = SSTC_CONV;
          end
          else if (autoOn && st.mode[`SSTC_BIT_LOOP])
          begin
            next_st.chan = ~st.chEn[0];
            next_st.seq  = SSTC_CONV;
          end
          else
          begin
            next_st.seq  = SSTC_IDLE;
            next_st.busy = 1'b0;
          end
        end
        default:
        begin
          next_st.seq  = SSTC_IDLE;
          next_st.busy = 1'b0;
        end
      endcase
    end

    if (gcReset)
    begin
      next_st = RST_STATE;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st <= RST_STATE;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign regRdData     = st.rdData;
  assign regRdValid    = st.rdValid;
  assign busyPin       = st.busy;
  assign activeChannel = st.chan;
  assign convDone      = st.convDone;
  assign oscLowPower   = st.osc;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence sLaunchOk;
    launchWr && !cancelWr && !gcReset && !(autoOn && st.chEn == 2'h0);
  endsequence

  sequence sCancel;
    cancelWr && !gcReset;
  endsequence

  a_launch_busy: assert property (sLaunchOk |=> busyPin && st.seq == SSTC_CONV)
    else $error("Launch did not start a conversion");
  a_cancel_idle: assert property (sCancel |=> !busyPin && st.seq == SSTC_IDLE)
    else $error("Cancel did not stop the conversion");
  a_launch_status: assert property (launchWr && !gcReset |=> st.fault != `SSTC_FAULT_ERR
    || $past(autoOn && st.chEn == 2'h0))
    else $error("Status not cleared on launch");
  a_fault_code: assert property (st.fault != 2'h2)
    else $error("Unused fault code reported");
  a_fill_clear: assert property (launchWr && !gcReset |=> st.fill == 5'h00)
    else $error("Fill count not cleared on launch");
  a_ctrl_readzero: assert property (regRead && !gcReset && (regAddr == `SSTC_ADDR_LAUNCH
    || regAddr == `SSTC_ADDR_CANCEL) |=> regRdValid && regRdData == 8'h00)
    else $error("Launch or cancel register read not zero");
  a_status_reserved: assert property (regRead && regAddr == `SSTC_ADDR_STATUS
    |=> regRdData[7:3] == 5'h00 && !regRdData[0])
    else $error("Status reserved bits not zero");
  a_osc_upper: assert property (regRead && regAddr == `SSTC_ADDR_OSC
    |=> regRdData[7:1] == 7'h00)
    else $error("Oscillator register upper bits not zero");
  a_manual_chan: assert property (sLaunchOk ##0 !autoOn |=> !activeChannel)
    else $error("Manual launch did not select first channel");
  a_auto_chan: assert property (sLaunchOk ##0 autoOn |=> st.chEn[activeChannel])
    else $error("Auto launch selected a disabled channel");
  a_gc_reset: assert property (gcReset |=> st.fault == `SSTC_FAULT_OFF && !busyPin
    && st.fill == 5'h00)
    else $error("General call reset did not clear state");
endmodule

// ===== sstc_host_model.sv
/*
  Host controller model: byte register reads and writes plus general-call reset.
  Assumes the device answers a read one clock after the read strobe.
*/
`timescale 1ns/1ps

module sstc_host_model
(
  // Clock
  input  wire logic       clk_sys,
  // Register access
  output logic      [7:0] regAddr,
  output logic      [7:0] regWrData,
  output logic            regWrite,
  output logic            regRead,
  output logic            gcReset,
  input  wire logic [7:0] regRdData,
  input  wire logic       regRdValid
);
  initial
  begin
    regAddr = 8'hFF;
    regWrData = 8'hFF;
    regWrite = 1'h0;
    regRead = 1'h0;
    gcReset = 1'h0;
  end

  // ****************************************
  // Accesses; released lines show inverted values
  // ****************************************
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1;
    regAddr = a;
    regWrData = d;
    regWrite = 1'h1;
    @(posedge clk_sys);
    #1;
    regWrite = 1'h0;
    regAddr = ~a;
    regWrData = ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge clk_sys);
    #1;
    regAddr = a;
    regRead = 1'h1;
    @(posedge clk_sys);
    #1;
    regRead = 1'h0;
    regAddr = ~a;
    v = regRdValid;
    d = regRdData;
  endtask

  task automatic gc();
    @(posedge clk_sys);
    #1;
    gcReset = 1'h1;
    @(posedge clk_sys);
    #1;
    gcReset = 1'h0;
  endtask
endmodule

// ===== sstc_scan_ctrl_test.sv
/*
  Self-checking bench of the scan sequence and timing control block.
  Assumes sstc_defs.svh on the include path and the host model beside it.
*/
`timescale 1ns/1ps
`include "sstc_defs.svh"

module sstc_scan_ctrl_test;
  logic       clk_sys = 1'h0;
  logic       rst_n = 1'h0;
  logic       hsOscClk = 1'h0;
  logic       lpOscClk = 1'h0;
  logic [7:0] regAddr;
  logic [7:0] regWrData;
  logic       regWrite;
  logic       regRead;
  logic       gcReset;
  logic [7:0] regRdData;
  logic       regRdValid;
  logic       busyPin;
  logic       activeChannel;
  logic       convDone;
  logic       oscLowPower;
  int         errTotal = 0;
  int         samplesChecked = 0;

  always #5 clk_sys = ~clk_sys;
  always #30 hsOscClk = ~hsOscClk;
  always #40 lpOscClk = ~lpOscClk;

  sstc_host_model i_host
  (
    .clk_sys    (clk_sys),
    .regAddr    (regAddr),
    .regWrData  (regWrData),
    .regWrite   (regWrite),
    .regRead    (regRead),
    .gcReset    (gcReset),
    .regRdData  (regRdData),
    .regRdValid (regRdValid)
  );

  sstc_scan_ctrl i_dut
  (
    .clk_sys       (clk_sys),
    .rst_n         (rst_n),
    .regAddr       (regAddr),
    .regWrData     (regWrData),
    .regWrite      (regWrite),
    .regRead       (regRead),
    .gcReset       (gcReset),
    .regRdData     (regRdData),
    .regRdValid    (regRdValid),
    .hsOscClk      (hsOscClk),
    .lpOscClk      (lpOscClk),
    .busyPin       (busyPin),
    .activeChannel (activeChannel),
    .convDone      (convDone),
    .oscLowPower   (oscLowPower)
  );

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    samplesChecked++;
    if (seen !== exp)
    begin
      errTotal++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       v;
    i_host.rd(a, d, v);
    chk("read valid", {7'h00, v}, 8'h01);
    chk($sformatf("reg %h", a), d, exp);
  endtask

  task automatic waitDone(output int k);
    k = 0;
    while (convDone !== 1'h1 && k < 3000)
    begin
      @(posedge clk_sys);
      #1;
      k++;
    end
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    rdChk(`SSTC_ADDR_STATUS, 8'h00);
    rdChk(`SSTC_ADDR_OSC, 8'h00);
    rdChk(`SSTC_ADDR_CYCLE, `SSTC_FLOOR_HS);
    rdChk(`SSTC_ADDR_LAUNCH, 8'h00);
    rdChk(`SSTC_ADDR_CANCEL, 8'h00);
    rdChk(`SSTC_ADDR_CHEN, 8'h03);
    rdChk(8'h05, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_clamp();
    i_host.wr(`SSTC_ADDR_CYCLE, 8'h15);
    rdChk(`SSTC_ADDR_CYCLE, 8'h15);
    i_host.wr(`SSTC_ADDR_CYCLE, 8'h16);
    rdChk(`SSTC_ADDR_CYCLE, 8'h16);
    i_host.wr(`SSTC_ADDR_OSC, 8'hFF);
    rdChk(`SSTC_ADDR_OSC, 8'h01);
    chk("osc pin", {7'h00, oscLowPower}, 8'h01);
    i_host.wr(`SSTC_ADDR_CYCLE, 8'h10);
    rdChk(`SSTC_ADDR_CYCLE, `SSTC_FLOOR_LP);
    i_host.wr(`SSTC_ADDR_CYCLE, 8'h13);
    rdChk(`SSTC_ADDR_CYCLE, 8'h13);
    $display("test clamp done");
  endtask

  task automatic t_conv(input logic lp, input logic [7:0] n, input int per);
    int k;
    i_host.wr(`SSTC_ADDR_MODE, 8'h00);
    i_host.wr(`SSTC_ADDR_OSC, {7'h00, lp});
    i_host.wr(`SSTC_ADDR_CYCLE, 8'h00);
    i_host.wr(`SSTC_ADDR_LAUNCH, 8'h01);
    chk("busy up", {7'h00, busyPin}, 8'h01);
    waitDone(k);
    chk("span", {7'h00, k >= (n - 1) * per && k <= n * per + 6}, 8'h01);
    repeat (4) @(posedge clk_sys);
    chk("busy end", {7'h00, busyPin}, 8'h00);
    rdChk(`SSTC_ADDR_STATUS, 8'h00);
    rdChk(`SSTC_ADDR_FILL, 8'h01);
    $display("test conversion done");
  endtask

  task automatic t_loop();
    int k;
    i_host.wr(`SSTC_ADDR_OSC, 8'h00);
    i_host.wr(`SSTC_ADDR_MODE, 8'h06);
    i_host.wr(`SSTC_ADDR_LAUNCH, 8'h01);
    chk("chan first", {7'h00, activeChannel}, 8'h00);
    rdChk(`SSTC_ADDR_STATUS, 8'h02);
    waitDone(k);
    repeat (3) @(posedge clk_sys);
    chk("chan second", {7'h00, activeChannel}, 8'h01);
    waitDone(k);
    repeat (3) @(posedge clk_sys);
    chk("chan wrap", {7'h00, activeChannel}, 8'h00);
    chk("busy loop", {7'h00, busyPin}, 8'h01);
    i_host.wr(`SSTC_ADDR_CANCEL, 8'h01);
    chk("busy cancel", {7'h00, busyPin}, 8'h00);
    rdChk(`SSTC_ADDR_FILL, 8'h02);
    i_host.wr(`SSTC_ADDR_LAUNCH, 8'h01);
    rdChk(`SSTC_ADDR_FILL, 8'h00);
    i_host.wr(`SSTC_ADDR_CANCEL, 8'h01);
    $display("test loop done");
  endtask

  task automatic t_pass();
    int k;
    i_host.wr(`SSTC_ADDR_MODE, 8'h04);
    i_host.wr(`SSTC_ADDR_LAUNCH, 8'h01);
    chk("pass first", {7'h00, activeChannel}, 8'h00);
    waitDone(k);
    repeat (3) @(posedge clk_sys);
    chk("pass second", {7'h00, activeChannel}, 8'h01);
    chk("pass busy", {7'h00, busyPin}, 8'h01);
    waitDone(k);
    repeat (3) @(posedge clk_sys);
    chk("pass end", {7'h00, busyPin}, 8'h00);
    rdChk(`SSTC_ADDR_FILL, 8'h02);
    i_host.wr(`SSTC_ADDR_CHEN, 8'h02);
    i_host.wr(`SSTC_ADDR_LAUNCH, 8'h01);
    chk("pass only second", {7'h00, activeChannel}, 8'h01);
    waitDone(k);
    repeat (3) @(posedge clk_sys);
    chk("pass single", {7'h00, busyPin}, 8'h00);
    rdChk(`SSTC_ADDR_FILL, 8'h01);
    $display("test pass done");
  endtask

  task automatic t_err();
    i_host.wr(`SSTC_ADDR_CHEN, 8'h00);
    i_host.wr(`SSTC_ADDR_MODE, 8'h04);
    i_host.wr(`SSTC_ADDR_LAUNCH, 8'h01);
    chk("busy refused", {7'h00, busyPin}, 8'h00);
    rdChk(`SSTC_ADDR_STATUS, 8'h06);
    i_host.gc();
    rdChk(`SSTC_ADDR_STATUS, 8'h00);
    rdChk(`SSTC_ADDR_CHEN, 8'h03);
    $display("test error done");
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", samplesChecked, errTotal);
    if (errTotal == 0 && samplesChecked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    #100us;
    errTotal++;
    results();
  end

  initial
  begin
    repeat (10) @(posedge clk_sys);
    #1;
    rst_n = 1'h1;
    t_reset();
    t_clamp();
    t_conv(1'h0, `SSTC_FLOOR_HS, 6);
    t_conv(1'h1, `SSTC_FLOOR_LP, 8);
    t_loop();
    t_pass();
    t_err();
    results();
  end
endmodule
